// ==== rtl/imucfg_regs.sv ====
// Configuration bank: flat interrupt, offset compensation, NVM enable, serial port setup
//
// Local design decision: register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "imucfg_map.svh"

module imucfg_regs
    import imucfg_pkg::*;
#(
    parameter int MS_CYCLES = `IMUCFG_MS_NS / `IMUCFG_CLK_PERIOD_NS
) (
    input  wire logic        sys_clk_i,
    input  wire logic        resetn_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [11:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    input  wire logic [3:0]  pstrb_i,
    output logic             pready_o,
    output logic [31:0]      prdata_o,
    output logic             pslverr_o,
    input  wire logic        flat_detect_i,
    input  wire logic        nvm_prog_req_i,
    output logic             flat_state_o,
    output logic             nvm_prog_go_o,
    output imucfg_flat_cfg_t flat_cfg_o,
    output imucfg_foc_cfg_t  foc_cfg_o,
    output imucfg_if_cfg_t   if_cfg_o,
    output logic             irq_o
);

    typedef struct packed {
        logic [5:0]               angle;
        logic [1:0]               hold;
        logic [2:0]               hyst;
        logic                     foc_gyr;
        logic [1:0]               foc_x;
        logic [1:0]               foc_y;
        logic [1:0]               foc_z;
        logic                     nvm_en;
        logic [1:0]               mode;
        logic                     three_wire;
        logic                     spi_only;
        logic [`IMUCFG_EV_W-1:0]  status;
        logic [`IMUCFG_EV_W-1:0]  mask;
        logic [31:0]              rdata;
        logic                     nvm_go;
    } imucfg_state_t;

    imucfg_state_t           st_reg;
    imucfg_state_t           st_next;
    imucfg_reg_sel_t         sel;
    logic                    setup_rd;
    logic                    access;
    logic                    wr_lane0;
    logic [7:0]              wbyte;
    logic [`IMUCFG_EV_W-1:0] events;
    logic                    flat_event;
    logic                    bad_mode_wr;

    // Shared by read capture and write decode; unaligned addresses map nowhere
    function automatic imucfg_reg_sel_t decode_addr(input logic [11:0] addr);
        logic [9:0] idx;
        idx = addr[11:2];
        if (addr[1:0] != 2'b00) begin
            return IMUCFG_SEL_NONE;
        end else if (idx == `IMUCFG_IDX_FLAT_ANGLE) begin
            return IMUCFG_SEL_FLAT_ANGLE;
        end else if (idx == `IMUCFG_IDX_FLAT_HOLD) begin
            return IMUCFG_SEL_FLAT_HOLD;
        end else if (idx == `IMUCFG_IDX_FOC_SETUP) begin
            return IMUCFG_SEL_FOC_SETUP;
        end else if (idx == `IMUCFG_IDX_NVM_CTRL) begin
            return IMUCFG_SEL_NVM_CTRL;
        end else if (idx == `IMUCFG_IDX_PORT_SETUP) begin
            return IMUCFG_SEL_PORT_SETUP;
        end else if (idx == `IMUCFG_IDX_IRQ_STATUS) begin
            return IMUCFG_SEL_IRQ_STATUS;
        end else if (idx == `IMUCFG_IDX_IRQ_MASK) begin
            return IMUCFG_SEL_IRQ_MASK;
        end else if (idx == `IMUCFG_IDX_PORT_OPTION) begin
            return IMUCFG_SEL_PORT_OPTION;
        end else begin
            return IMUCFG_SEL_NONE;
        end
    endfunction

    assign sel      = decode_addr(paddr_i);
    assign setup_rd = psel_i && !penable_i && !pwrite_i;
    assign access   = psel_i && penable_i;
    assign wr_lane0 = access && pwrite_i && pstrb_i[0];
    assign wbyte    = pwdata_i[7:0];

    // Zero-wait slave: read data is captured in the setup cycle
    assign pready_o  = access;
    assign pslverr_o = access && (sel == IMUCFG_SEL_NONE);
    assign prdata_o  = st_reg.rdata;

    imucfg_flat_hold #(
        .MS_CYCLES (MS_CYCLES)
    ) u_flat_hold (
        .sys_clk_i    (sys_clk_i),
        .resetn_i     (resetn_i),
        .flat_i       (flat_detect_i),
        .hold_code_i  (st_reg.hold),
        .flat_o       (flat_state_o),
        .flat_event_o (flat_event)
    );

    // Mode 11 is undefined; flag it so software can see the misuse
    assign bad_mode_wr = wr_lane0 && (sel == IMUCFG_SEL_PORT_SETUP)
                         && (wbyte[`IMUCFG_MODE_MSB:`IMUCFG_MODE_LSB] == 2'b11);

    always_comb begin
        events                         = '0;
        events[`IMUCFG_EV_FLAT]        = flat_event;
        events[`IMUCFG_EV_NVM_DONE]    = nvm_prog_req_i && st_reg.nvm_en;
        events[`IMUCFG_EV_NVM_BLOCK]   = nvm_prog_req_i && !st_reg.nvm_en;
        events[`IMUCFG_EV_BAD_MODE]    = bad_mode_wr;
    end

    always_comb begin
        st_next        = st_reg;
        st_next.nvm_go = nvm_prog_req_i && st_reg.nvm_en;

        if (setup_rd) begin
            st_next.rdata = 32'h0000_0000;
            case (sel)
                IMUCFG_SEL_FLAT_ANGLE: begin
                    st_next.rdata[`IMUCFG_ANGLE_MSB:0] = st_reg.angle;
                end
                IMUCFG_SEL_FLAT_HOLD: begin
                    st_next.rdata[`IMUCFG_HOLD_MSB:`IMUCFG_HOLD_LSB] = st_reg.hold;
                    st_next.rdata[`IMUCFG_HYST_MSB:0]                = st_reg.hyst;
                end
                IMUCFG_SEL_FOC_SETUP: begin
                    st_next.rdata[`IMUCFG_FOC_GYR_BIT]                     = st_reg.foc_gyr;
                    st_next.rdata[`IMUCFG_FOC_X_LSB+1:`IMUCFG_FOC_X_LSB] = st_reg.foc_x;
                    st_next.rdata[`IMUCFG_FOC_Y_LSB+1:`IMUCFG_FOC_Y_LSB] = st_reg.foc_y;
                    st_next.rdata[`IMUCFG_FOC_Z_LSB+1:`IMUCFG_FOC_Z_LSB] = st_reg.foc_z;
                end
                IMUCFG_SEL_NVM_CTRL: begin
                    st_next.rdata[`IMUCFG_NVM_EN_BIT] = st_reg.nvm_en;
                end
                IMUCFG_SEL_PORT_SETUP: begin
                    st_next.rdata[`IMUCFG_MODE_MSB:`IMUCFG_MODE_LSB] = st_reg.mode;
                    st_next.rdata[`IMUCFG_THREE_WIRE_BIT]            = st_reg.three_wire;
                end
                IMUCFG_SEL_IRQ_STATUS: begin
                    st_next.rdata[`IMUCFG_EV_W-1:0] = st_reg.status;
                end
                IMUCFG_SEL_IRQ_MASK: begin
                    st_next.rdata[`IMUCFG_EV_W-1:0] = st_reg.mask;
                end
                IMUCFG_SEL_PORT_OPTION: begin
                    st_next.rdata[`IMUCFG_SPI_ONLY_BIT] = st_reg.spi_only;
                end
                default: begin
                    st_next.rdata = 32'h0000_0000;
                end
            endcase
        end

        // Reserved bits are not stored, so they always read back as zero
        if (wr_lane0) begin
            case (sel)
                IMUCFG_SEL_FLAT_ANGLE: begin
                    st_next.angle = wbyte[`IMUCFG_ANGLE_MSB:0];
                end
                IMUCFG_SEL_FLAT_HOLD: begin
                    st_next.hold = wbyte[`IMUCFG_HOLD_MSB:`IMUCFG_HOLD_LSB];
                    st_next.hyst = wbyte[`IMUCFG_HYST_MSB:0];
                end
                IMUCFG_SEL_FOC_SETUP: begin
                    st_next.foc_gyr = wbyte[`IMUCFG_FOC_GYR_BIT];
                    st_next.foc_x   = wbyte[`IMUCFG_FOC_X_LSB+1:`IMUCFG_FOC_X_LSB];
                    st_next.foc_y   = wbyte[`IMUCFG_FOC_Y_LSB+1:`IMUCFG_FOC_Y_LSB];
                    st_next.foc_z   = wbyte[`IMUCFG_FOC_Z_LSB+1:`IMUCFG_FOC_Z_LSB];
                end
                IMUCFG_SEL_NVM_CTRL: begin
                    st_next.nvm_en = wbyte[`IMUCFG_NVM_EN_BIT];
                end
                IMUCFG_SEL_PORT_SETUP: begin
                    st_next.mode       = wbyte[`IMUCFG_MODE_MSB:`IMUCFG_MODE_LSB];
                    st_next.three_wire = wbyte[`IMUCFG_THREE_WIRE_BIT];
                end
                IMUCFG_SEL_IRQ_MASK: begin
                    st_next.mask = wbyte[`IMUCFG_EV_W-1:0];
                end
                IMUCFG_SEL_PORT_OPTION: begin
                    st_next.spi_only = wbyte[`IMUCFG_SPI_ONLY_BIT];
                end
                default: begin
                end
            endcase
        end

        // Clear only the bits the setup cycle captured for the reader; an event
        // that lands during the setup or access cycle stays pending
        if (access && !pwrite_i && (sel == IMUCFG_SEL_IRQ_STATUS)) begin
            st_next.status = (st_reg.status & ~st_reg.rdata[`IMUCFG_EV_W-1:0]) | events;
        end else begin
            st_next.status = st_reg.status | events;
        end
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            // Reset images other than the 4-bit IRQ one are whole bytes; each field keeps only its own slice
            st_reg            <= '0;
            st_reg.angle      <= 6'(`IMUCFG_RST_FLAT_ANGLE);
            st_reg.hold       <= 2'(`IMUCFG_RST_FLAT_HOLD >> `IMUCFG_HOLD_LSB);
            st_reg.hyst       <= 3'(`IMUCFG_RST_FLAT_HOLD);
            st_reg.foc_gyr    <= 1'(`IMUCFG_RST_FOC_SETUP >> `IMUCFG_FOC_GYR_BIT);
            st_reg.foc_x      <= 2'(`IMUCFG_RST_FOC_SETUP >> `IMUCFG_FOC_X_LSB);
            st_reg.foc_y      <= 2'(`IMUCFG_RST_FOC_SETUP >> `IMUCFG_FOC_Y_LSB);
            st_reg.foc_z      <= 2'(`IMUCFG_RST_FOC_SETUP >> `IMUCFG_FOC_Z_LSB);
            st_reg.nvm_en     <= 1'(`IMUCFG_RST_NVM_CTRL >> `IMUCFG_NVM_EN_BIT);
            st_reg.mode       <= 2'(`IMUCFG_RST_PORT_SETUP >> `IMUCFG_MODE_LSB);
            st_reg.three_wire <= 1'(`IMUCFG_RST_PORT_SETUP);
            st_reg.status     <= `IMUCFG_RST_IRQ;
            st_reg.mask       <= `IMUCFG_RST_IRQ;
        end else begin
            st_reg <= st_next;
        end
    end

    assign nvm_prog_go_o = st_reg.nvm_go;
    assign irq_o         = |(st_reg.status & st_reg.mask);

    always_comb begin
        flat_cfg_o.angle      = st_reg.angle;
        flat_cfg_o.hold       = st_reg.hold;
        flat_cfg_o.hysteresis = st_reg.hyst;
        foc_cfg_o.gyro_en     = st_reg.foc_gyr;
        foc_cfg_o.acc_x       = imucfg_foc_target_t'(st_reg.foc_x);
        foc_cfg_o.acc_y       = imucfg_foc_target_t'(st_reg.foc_y);
        foc_cfg_o.acc_z       = imucfg_foc_target_t'(st_reg.foc_z);
    end

    // Undefined mode 11 falls back to the safe reset behaviour of mode 00
    always_comb begin
        if_cfg_o.three_wire_select = st_reg.three_wire;
        if_cfg_o.primary_auto      = 1'b1;
        if_cfg_o.primary_i2c_only  = 1'b0;
        if_cfg_o.secondary         = IMUCFG_SEC_OFF;
        case (st_reg.mode)
            2'b00: begin
                if_cfg_o.secondary = IMUCFG_SEC_OFF;
            end
            2'b01: begin
                if_cfg_o.primary_auto     = 1'b0;
                if_cfg_o.primary_i2c_only = 1'b1;
                if_cfg_o.secondary        = IMUCFG_SEC_OPTICAL;
            end
            2'b10: begin
                if_cfg_o.secondary = IMUCFG_SEC_MAGNETOMETER;
            end
            default: begin
                if_cfg_o.secondary = IMUCFG_SEC_OFF;
            end
        endcase
        if_cfg_o.i2c_disabled = st_reg.spi_only && if_cfg_o.primary_auto;
    end

endmodule
`default_nettype wire

// ==== rtl/imucfg_map.svh ====
// Register indices, field positions, reset values and timing constants
`ifndef IMUCFG_MAP_SVH
`define IMUCFG_MAP_SVH

// Register indices; the byte address is four times the index
`define IMUCFG_IDX_FLAT_ANGLE   10'h067
`define IMUCFG_IDX_FLAT_HOLD    10'h068
`define IMUCFG_IDX_FOC_SETUP    10'h069
`define IMUCFG_IDX_NVM_CTRL     10'h06a
`define IMUCFG_IDX_PORT_SETUP   10'h06b
`define IMUCFG_IDX_IRQ_STATUS   10'h060
`define IMUCFG_IDX_IRQ_MASK     10'h061
`define IMUCFG_IDX_PORT_OPTION  10'h062

// Reset values
`define IMUCFG_RST_FLAT_ANGLE   8'h08
`define IMUCFG_RST_FLAT_HOLD    8'h11
`define IMUCFG_RST_FOC_SETUP    8'h00
`define IMUCFG_RST_NVM_CTRL     8'h00
`define IMUCFG_RST_PORT_SETUP   8'h00
`define IMUCFG_RST_IRQ          4'h0

// Field positions
`define IMUCFG_ANGLE_MSB        5
`define IMUCFG_HYST_MSB         2
`define IMUCFG_HOLD_LSB         4
`define IMUCFG_HOLD_MSB         5
`define IMUCFG_FOC_GYR_BIT      6
`define IMUCFG_FOC_X_LSB        4
`define IMUCFG_FOC_Y_LSB        2
`define IMUCFG_FOC_Z_LSB        0
`define IMUCFG_NVM_EN_BIT       1
`define IMUCFG_THREE_WIRE_BIT   0
`define IMUCFG_MODE_LSB         4
`define IMUCFG_MODE_MSB         5
`define IMUCFG_SPI_ONLY_BIT     0

// Interrupt status bits
`define IMUCFG_EV_FLAT          0
`define IMUCFG_EV_NVM_DONE      1
`define IMUCFG_EV_NVM_BLOCK     2
`define IMUCFG_EV_BAD_MODE      3
`define IMUCFG_EV_W             4

// Timing
`define IMUCFG_CLK_PERIOD_NS    10
`define IMUCFG_MS_NS            1000000
`define IMUCFG_HOLD1_MS         12'd640
`define IMUCFG_HOLD2_MS         12'd1280
`define IMUCFG_HOLD3_MS         12'd2560

`endif

// ==== rtl/imucfg_pkg.sv ====
// Types shared by the configuration bank and the flat hold timer
package imucfg_pkg;

    typedef enum logic [1:0] {
        IMUCFG_FOC_OFF,
        IMUCFG_FOC_PLUS_1G,
        IMUCFG_FOC_MINUS_1G,
        IMUCFG_FOC_ZERO_G
    } imucfg_foc_target_t;

    typedef enum logic [1:0] {
        IMUCFG_SEC_OFF,
        IMUCFG_SEC_OPTICAL,
        IMUCFG_SEC_MAGNETOMETER
    } imucfg_secondary_t;

    typedef enum logic [3:0] {
        IMUCFG_SEL_NONE,
        IMUCFG_SEL_FLAT_ANGLE,
        IMUCFG_SEL_FLAT_HOLD,
        IMUCFG_SEL_FOC_SETUP,
        IMUCFG_SEL_NVM_CTRL,
        IMUCFG_SEL_PORT_SETUP,
        IMUCFG_SEL_IRQ_STATUS,
        IMUCFG_SEL_IRQ_MASK,
        IMUCFG_SEL_PORT_OPTION
    } imucfg_reg_sel_t;

    typedef struct packed {
        logic [5:0] angle;
        logic [1:0] hold;
        logic [2:0] hysteresis;
    } imucfg_flat_cfg_t;

    typedef struct packed {
        logic               gyro_en;
        imucfg_foc_target_t acc_x;
        imucfg_foc_target_t acc_y;
        imucfg_foc_target_t acc_z;
    } imucfg_foc_cfg_t;

    typedef struct packed {
        logic              three_wire_select;
        logic              primary_auto;
        logic              primary_i2c_only;
        logic              i2c_disabled;
        imucfg_secondary_t secondary;
    } imucfg_if_cfg_t;

endpackage

// ==== rtl/imucfg_flat_hold.sv ====
// Flat hold timer: flags the flat state once it has stayed unchanged for the hold time
`timescale 1ns/1ps
`default_nettype none
`include "imucfg_map.svh"

module imucfg_flat_hold
    import imucfg_pkg::*;
#(
    parameter int MS_CYCLES = `IMUCFG_MS_NS / `IMUCFG_CLK_PERIOD_NS
) (
    input  wire logic       sys_clk_i,
    input  wire logic       resetn_i,
    input  wire logic       flat_i,
    input  wire logic [1:0] hold_code_i,
    output logic            flat_o,
    output logic            flat_event_o
);

    typedef struct packed {
        logic        prev;
        logic        armed;
        logic [31:0] div;
        logic [11:0] ms;
        logic        flat;
        logic        event_p;
    } imucfg_hold_state_t;

    imucfg_hold_state_t st_reg;
    imucfg_hold_state_t st_next;
    logic [11:0]        target;

    always_comb begin
        case (hold_code_i)
            2'b01:   target = `IMUCFG_HOLD1_MS;
            2'b10:   target = `IMUCFG_HOLD2_MS;
            2'b11:   target = `IMUCFG_HOLD3_MS;
            default: target = 12'h000;
        endcase
    end

    always_comb begin
        st_next         = st_reg;
        st_next.event_p = 1'b0;
        st_next.prev    = flat_i;
        if (flat_i != st_reg.prev) begin
            // Any change of the flat value restarts the stability window
            st_next.armed = 1'b1;
            st_next.div   = 32'h0000_0000;
            st_next.ms    = 12'h000;
        end else if (st_reg.armed) begin
            if (st_reg.ms >= target) begin
                st_next.armed   = 1'b0;
                st_next.flat    = st_reg.prev;
                st_next.event_p = 1'b1;
            end else if (st_reg.div == 32'(MS_CYCLES - 1)) begin
                st_next.div = 32'h0000_0000;
                st_next.ms  = st_reg.ms + 12'h001;
            end else begin
                st_next.div = st_reg.div + 32'h0000_0001;
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign flat_o       = st_reg.flat;
    assign flat_event_o = st_reg.event_p;

endmodule
`default_nettype wire

// ==== test/imucfg_regs_monitor.sv ====
// Port checker for the configuration bank
`timescale 1ns/1ps
`default_nettype none
`include "imucfg_map.svh"

module imucfg_regs_monitor
    import imucfg_pkg::*;
(
    input  wire logic             sys_clk_i,
    input  wire logic             resetn_i,
    input  wire logic             psel_i,
    input  wire logic             penable_i,
    input  wire logic             pwrite_i,
    input  wire logic [11:0]      paddr_i,
    input  wire logic [31:0]      pwdata_i,
    input  wire logic [3:0]       pstrb_i,
    input  wire logic             nvm_prog_req_i,
    input  wire logic             nvm_prog_go_o,
    input  wire imucfg_flat_cfg_t flat_cfg_o,
    input  wire imucfg_foc_cfg_t  foc_cfg_o,
    input  wire imucfg_if_cfg_t   if_cfg_o
);
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!resetn_i);

    logic wr;
    assign wr = psel_i && penable_i && pwrite_i && pstrb_i[0];

    property p_angle;
        wr && paddr_i == {`IMUCFG_IDX_FLAT_ANGLE, 2'b00}
            |=> flat_cfg_o.angle == $past(pwdata_i[5:0]);
    endproperty
    a_angle: assert property (p_angle) else $error("angle not stored");
    property p_hold;
        wr && paddr_i == {`IMUCFG_IDX_FLAT_HOLD, 2'b00} |=> flat_cfg_o.hold == $past(pwdata_i[5:4])
            && flat_cfg_o.hysteresis == $past(pwdata_i[2:0]);
    endproperty
    a_hold: assert property (p_hold) else $error("hold or hysteresis not stored");
    property p_foc;
        wr && paddr_i == {`IMUCFG_IDX_FOC_SETUP, 2'b00} |=> foc_cfg_o == $past(pwdata_i[6:0]);
    endproperty
    a_foc: assert property (p_foc) else $error("compensation setup not stored");
    property p_go;
        nvm_prog_go_o |-> $past(nvm_prog_req_i);
    endproperty
    a_go: assert property (p_go) else $error("program start without request");
    property p_wire;
        wr && paddr_i == {`IMUCFG_IDX_PORT_SETUP, 2'b00}
            |=> if_cfg_o.three_wire_select == $past(pwdata_i[0]);
    endproperty
    a_wire: assert property (p_wire) else $error("wire select not stored");
    property p_off;
        if_cfg_o.secondary == IMUCFG_SEC_OFF |-> if_cfg_o.primary_auto && !if_cfg_o.primary_i2c_only;
    endproperty
    a_off: assert property (p_off) else $error("mode off decode wrong");
    property p_opt;
        if_cfg_o.secondary == IMUCFG_SEC_OPTICAL |-> if_cfg_o.primary_i2c_only && !if_cfg_o.primary_auto;
    endproperty
    a_opt: assert property (p_opt) else $error("optical mode decode wrong");
    property p_mag;
        if_cfg_o.secondary == IMUCFG_SEC_MAGNETOMETER |-> if_cfg_o.primary_auto;
    endproperty
    a_mag: assert property (p_mag) else $error("magnetometer mode decode wrong");
    property p_spi;
        if_cfg_o.i2c_disabled |-> if_cfg_o.primary_auto;
    endproperty
    a_spi: assert property (p_spi) else $error("option acts outside auto mode");
endmodule

bind imucfg_regs imucfg_regs_monitor u_mon (.sys_clk_i, .resetn_i, .psel_i, .penable_i,
    .pwrite_i, .paddr_i, .pwdata_i, .pstrb_i, .nvm_prog_req_i, .nvm_prog_go_o, .flat_cfg_o,
    .foc_cfg_o, .if_cfg_o);

`default_nettype wire

// ==== test/imucfg_host_model.sv ====
// Host model: runs one APB transfer per command from the bench
`timescale 1ns/1ps
`default_nettype none

module imucfg_host_model (
    input  wire logic        sys_clk_i,
    input  wire logic        resetn_i,
    input  wire logic        go_i,
    input  wire logic        wr_i,
    input  wire logic [11:0] addr_i,
    input  wire logic [31:0] data_i,
    output logic             done_o,
    output logic [31:0]      rdata_o,
    output logic             err_o,
    output logic             psel_o,
    output logic             penable_o,
    output logic             pwrite_o,
    output logic [11:0]      paddr_o,
    output logic [31:0]      pwdata_o,
    output logic [3:0]       pstrb_o,
    input  wire logic        pready_i,
    input  wire logic [31:0] prdata_i,
    input  wire logic        pslverr_i
);
    assign pstrb_o = 4'h1;

    always @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            psel_o <= 1'b0;
            penable_o <= 1'b0;
            done_o <= 1'b0;
            pwrite_o <= 1'b0;
            paddr_o <= 12'h000;
            pwdata_o <= 32'h0;
            rdata_o <= 32'h0;
            err_o <= 1'b0;
        end else begin
            done_o <= 1'b0;
            if (!psel_o && go_i) begin
                psel_o <= 1'b1;
                pwrite_o <= wr_i;
                paddr_o <= addr_i;
                pwdata_o <= data_i;
            end else if (psel_o && !penable_o) begin
                penable_o <= 1'b1;
            end else if (penable_o && pready_i) begin
                psel_o <= 1'b0;
                penable_o <= 1'b0;
                done_o <= 1'b1;
                rdata_o <= prdata_i;
                err_o <= pslverr_i;
                // Idle data must not look like the last transfer
                pwdata_o <= ~pwdata_o;
                paddr_o <= ~paddr_o;
            end
        end
    end
endmodule

`default_nettype wire

// ==== test/imucfg_regs_bench.sv ====
// Self-checking bench for the configuration bank
`timescale 1ns/1ps
`default_nettype none
`include "imucfg_map.svh"

module imucfg_regs_bench
    import imucfg_pkg::*;
;
    localparam int          MS     = 4;
    localparam logic [11:0] A_ANG  = {`IMUCFG_IDX_FLAT_ANGLE, 2'b00};
    localparam logic [11:0] A_HOLD = {`IMUCFG_IDX_FLAT_HOLD, 2'b00};
    localparam logic [11:0] A_FOC  = {`IMUCFG_IDX_FOC_SETUP, 2'b00};
    localparam logic [11:0] A_NVM  = {`IMUCFG_IDX_NVM_CTRL, 2'b00};
    localparam logic [11:0] A_PORT = {`IMUCFG_IDX_PORT_SETUP, 2'b00};
    localparam logic [11:0] A_STAT = {`IMUCFG_IDX_IRQ_STATUS, 2'b00};
    localparam logic [11:0] A_MASK = {`IMUCFG_IDX_IRQ_MASK, 2'b00};
    localparam logic [11:0] A_OPT  = {`IMUCFG_IDX_PORT_OPTION, 2'b00};

    logic             sys_clk_i, resetn_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
    logic             flat_detect_i, nvm_prog_req_i, flat_state_o, nvm_prog_go_o, irq_o;
    logic             go, wr, done, err;
    logic [11:0]      paddr_i, addr;
    logic [31:0]      pwdata_i, prdata_o, wdata, rdata;
    logic [3:0]       pstrb_i;
    imucfg_flat_cfg_t flat_cfg_o;
    imucfg_foc_cfg_t  foc_cfg_o;
    imucfg_if_cfg_t   if_cfg_o;
    int               miscompares = 0, checked = 0, cycles = 0;

    imucfg_regs #(.MS_CYCLES(MS)) DUT (.sys_clk_i, .resetn_i, .psel_i, .penable_i, .pwrite_i,
        .paddr_i, .pwdata_i, .pstrb_i, .pready_o, .prdata_o, .pslverr_o, .flat_detect_i,
        .nvm_prog_req_i, .flat_state_o, .nvm_prog_go_o, .flat_cfg_o, .foc_cfg_o, .if_cfg_o, .irq_o);

    imucfg_host_model u_host (.sys_clk_i, .resetn_i, .go_i(go), .wr_i(wr), .addr_i(addr),
        .data_i(wdata), .done_o(done), .rdata_o(rdata), .err_o(err), .psel_o(psel_i),
        .penable_o(penable_i), .pwrite_o(pwrite_i), .paddr_o(paddr_i), .pwdata_o(pwdata_i),
        .pstrb_o(pstrb_i), .pready_i(pready_o), .prdata_i(prdata_o), .pslverr_i(pslverr_o));

    task automatic test_done();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: %s got %h want %h", $time, msg, got, exp);
        end
    endtask

    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge sys_clk_i);
        go <= 1'b1;
        wr <= w;
        addr <= a;
        wdata <= d;
        @(posedge sys_clk_i);
        go <= 1'b0;
        // No local limit: only the bench cycle ceiling ends a hung transfer
        do begin
            @(posedge sys_clk_i);
            #1;
        end while (!done);
        chk(done, 1'b1, "bus answer");
    endtask

    task automatic t_reset();
        logic [11:0] zr[3] = '{A_FOC, A_NVM, A_PORT};
        bus(0, A_ANG, 0);
        chk(rdata, 32'h08, "angle reset");
        bus(0, A_HOLD, 0);
        chk(rdata, 32'h11, "hold reset");
        chk(flat_cfg_o, {6'h08, 2'h1, 3'h1}, "flat outputs");
        foreach (zr[i]) begin
            bus(0, zr[i], 0);
            chk(rdata, 32'h0, "zero reset");
        end
        chk(if_cfg_o, {1'b0, 1'b1, 1'b0, 1'b0, IMUCFG_SEC_OFF}, "port reset");
        bus(0, 12'h000, 0);
        chk(err, 1'b1, "unmapped read error");
        chk(rdata, 32'h0, "unmapped read data");
        bus(1, A_ANG + 12'h1, 32'h3f);
        chk(err, 1'b1, "unaligned write");
        chk(flat_cfg_o.angle, 6'h08, "unaligned write ignored");
    endtask

    task automatic t_port();
        imucfg_if_cfg_t e;
        bus(0, A_STAT, 0);
        bus(1, A_OPT, 32'h1);
        for (int m = 0; m < 4; m++) begin
            bus(1, A_PORT, {26'h0, m[1:0], 3'h0, m[0]});
            e.three_wire_select = m[0];
            e.primary_auto = (m != 1);
            e.primary_i2c_only = (m == 1);
            e.i2c_disabled = (m != 1);
            e.secondary = m == 1 ? IMUCFG_SEC_OPTICAL : m == 2 ? IMUCFG_SEC_MAGNETOMETER : IMUCFG_SEC_OFF;
            chk(if_cfg_o, e, "port decode");
        end
        bus(0, A_STAT, 0);
        chk(rdata[3], 1'b1, "bad mode event");
        bus(1, A_OPT, 32'h0);
        bus(1, A_PORT, 32'h0);
        chk(if_cfg_o.i2c_disabled, 1'b0, "option off");
    endtask

    task automatic t_nvm();
        bus(0, A_STAT, 0);
        bus(1, A_MASK, 32'h2);
        for (int en = 0; en < 2; en++) begin
            bus(1, A_NVM, {30'h0, en[0], 1'b0});
            @(posedge sys_clk_i);
            nvm_prog_req_i <= 1'b1;
            @(posedge sys_clk_i);
            nvm_prog_req_i <= 1'b0;
            #1;
            chk(nvm_prog_go_o, en[0], "program start");
            chk(irq_o, en[0], "masked interrupt");
            bus(0, A_STAT, 0);
            chk(rdata & 32'h6, en ? 32'h2 : 32'h4, "program status");
            chk(irq_o, 1'b0, "interrupt cleared");
            bus(0, A_STAT, 0);
            chk(rdata, 32'h0, "status read clear");
        end
    endtask

    task automatic t_foc();
        logic [31:0] d;
        for (int c = 0; c < 4; c++) begin
            d = {25'h0, c[0], c[1:0], 2'(c + 1), 2'(c + 2)};
            bus(1, A_FOC, d);
            chk(foc_cfg_o, d, "compensation fields");
            bus(0, A_FOC, 0);
            chk(rdata, d, "compensation readback");
        end
    endtask

    task automatic t_flat();
        for (int h = 0; h < 4; h++) begin
            bus(1, A_ANG, h[0] ? 32'h3f : 32'h0);
            chk(flat_cfg_o.angle, h[0] ? 6'h3f : 6'h0, "angle span");
            bus(1, A_HOLD, {26'h0, h[1:0], 1'b0, 3'(7 - h)});
            chk({flat_cfg_o.hold, flat_cfg_o.hysteresis}, {h[1:0], 3'(7 - h)}, "hold");
        end
        bus(1, A_HOLD, 32'h0);
        @(posedge sys_clk_i);
        flat_detect_i <= 1'b1;
        repeat (10) @(posedge sys_clk_i);
        chk(flat_state_o, 1'b1, "no delay");
        bus(1, A_HOLD, 32'h10);
        bus(0, A_STAT, 0);
        @(posedge sys_clk_i);
        flat_detect_i <= 1'b0;
        // 640 ms scaled to MS cycles per ms
        repeat (640 * MS - 20) @(posedge sys_clk_i);
        chk(flat_state_o, 1'b1, "early flat change");
        repeat (60) @(posedge sys_clk_i);
        chk(flat_state_o, 1'b0, "late flat change");
        bus(0, A_STAT, 0);
        chk(rdata[0], 1'b1, "flat event");
    endtask

    initial begin
        sys_clk_i = 1'b0;
        forever #5 sys_clk_i = ~sys_clk_i;
    end

    always @(posedge sys_clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares++;
            test_done();
        end
    end

    initial begin
        resetn_i = 1'b0;
        flat_detect_i = 1'b0;
        nvm_prog_req_i = 1'b0;
        go = 1'b0;
        wr = 1'b0;
        addr = 12'h000;
        wdata = 32'h0;
        repeat (3) @(posedge sys_clk_i);
        resetn_i <= 1'b1;
        t_reset();
        t_port();
        t_nvm();
        t_foc();
        t_flat();
        test_done();
    end
endmodule

`default_nettype wire
